// ===== hw/dual_wiper_serial_command.sv
// Command core of a dual 1024-position wiper controller with a serial link.
// Assumes the link pins, preset and write-protect are asynchronous pins.

// ------------------------------------------------------------------
// Function
// ------------------------------------------------------------------
module dual_wiper_serial_command #(
  parameter int STORE_CYCLES = wiper_pkg::STORE_CYCLES,
  parameter logic [15:0] FACTORY_WORD = 16'h5a5a  // Arbitrary value.
) (
  input wire logic clk_sys,          // System clock, 40 MHz.
  input wire logic rstn,             // Synchronous reset, active low.
  input wire logic ce,               // Clock enable; low freezes all.
  input wire logic sclk,             // Link clock pin.
  input wire logic sdi,              // Serial data in pin.
  input wire logic cs_n,             // Chip select pin, active low.
  output logic sdo_o,                // Serial out drive level.
  output logic sdo_oe,               // Serial out pull-down enable.
  output logic rdy_o,                // Completion flag drive level.
  output logic rdy_oe,               // Completion flag pull-down enable.
  input wire logic preset_strobe_n,  // Preset strobe pin, active low.
  input wire logic write_protect_n,  // Write-protect pin, active low.
  output logic [9:0] wiper_one,      // Position of wiper one.
  output logic [9:0] wiper_two,      // Position of wiper two.
  output logic store_busy,           // Nonvolatile store in progress.
  output logic read_power            // Read power state active.
);

  typedef struct packed {
    wiper_pkg::core_state_e st;
    logic [9:0] w1;
    logic [9:0] w2;
    logic [15:0][15:0] nv;
    logic [23:0] last;
    logic have_last;
    logic [19:0] busy_cnt;
    logic [3:0] st_addr;
    logic [15:0] st_data;
    logic [2:0] rdy_cnt;
    logic rd_pwr;
    logic [2:0] pr_s;
    logic [1:0] wp_s;
    logic load_stb;
    logic [23:0] load_word;
  } core_s;

  core_s q;
  core_s d;
  core_s rst_val;

  frame_link_if lk ();

  // ----------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------
  serial_front u_front (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .sclk(sclk),
    .sdi(sdi),
    .cs_n(cs_n),
    .sdo_o(sdo_o),
    .sdo_oe(sdo_oe),
    .lk(lk.front)
  );

  // ----------------------------------------------------------------
  // Wiper arithmetic
  // ----------------------------------------------------------------
  function automatic logic [9:0] step(input logic [9:0] w,
                                      input logic [3:0] op);
    logic [9:0] r;
    r = w;
    unique case (op)
      wiper_pkg::CMD_HALVE_ONE, wiper_pkg::CMD_HALVE_ALL:
        r = {1'b0, w[9:1]};
      wiper_pkg::CMD_DEC_ONE, wiper_pkg::CMD_DEC_ALL:
        r = (w == 10'h0) ? 10'h0 : w - 10'h1;
      wiper_pkg::CMD_DOUBLE_ONE, wiper_pkg::CMD_DOUBLE_ALL:
        r = w[9] ? wiper_pkg::WIPER_FULL : {w[8:0], 1'b0};
      wiper_pkg::CMD_INC_ONE, wiper_pkg::CMD_INC_ALL:
        r = (w == wiper_pkg::WIPER_FULL) ? w : w + 10'h1;
      default:
        r = w;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------
  always_comb begin
    rst_val = '0;
    rst_val.st = wiper_pkg::ST_POWERUP;
    rst_val.w1 = wiper_pkg::WIPER_MID;
    rst_val.w2 = wiper_pkg::WIPER_MID;
    rst_val.nv[0] = wiper_pkg::NV_MID;
    rst_val.nv[1] = wiper_pkg::NV_MID;
    rst_val.nv[wiper_pkg::NV_FACTORY_ADDR] = FACTORY_WORD;
    rst_val.pr_s = 3'h7;
    rst_val.wp_s = 2'h3;
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  logic go;
  logic [23:0] cmd_word;
  logic [3:0] instr;
  logic [3:0] addr;
  logic [15:0] data;
  logic sel;
  logic wp_ok;
  logic [9:0] w_sel;

  always_comb begin
    d = q;
    d.load_stb = 1'b0;
    d.pr_s = {q.pr_s[1:0], preset_strobe_n};
    d.wp_s = {q.wp_s[0], write_protect_n};
    if (q.rdy_cnt != 3'h0) begin
      d.rdy_cnt = q.rdy_cnt - 3'h1;
    end

    go = 1'b0;
    cmd_word = lk.frame_word;
    if (q.st == wiper_pkg::ST_IDLE) begin
      if (lk.frame_stb) begin
        go = 1'b1;
        d.last = lk.frame_word;
        d.have_last = 1'b1;
      end else if (lk.repeat_stb && q.have_last) begin
        go = 1'b1;
        cmd_word = q.last;
      end
    end
    instr = cmd_word[23:20];
    addr = cmd_word[19:16];
    data = cmd_word[15:0];
    sel = addr[0];
    wp_ok = q.wp_s[1];
    w_sel = sel ? q.w2 : q.w1;

    unique case (q.st)
      wiper_pkg::ST_POWERUP: begin
        d.w1 = q.nv[0][9:0];
        d.w2 = q.nv[1][9:0];
        d.st = wiper_pkg::ST_IDLE;
      end
      wiper_pkg::ST_STORE: begin
        if (q.busy_cnt == 20'h0) begin
          d.nv[q.st_addr] = q.st_data;
          d.st = wiper_pkg::ST_IDLE;
          d.rdy_cnt = wiper_pkg::RDY_PULSE_CYCLES;
        end else begin
          d.busy_cnt = q.busy_cnt - 20'h1;
        end
      end
      wiper_pkg::ST_IDLE: begin
        if (go) begin
          unique case (instr)
            wiper_pkg::CMD_NOP: begin
              d.rd_pwr = 1'b0;
            end
            wiper_pkg::CMD_RESTORE: begin
              d.rd_pwr = 1'b1;
              if (sel) begin
                d.w2 = q.nv[1][9:0];
              end else begin
                d.w1 = q.nv[0][9:0];
              end
            end
            wiper_pkg::CMD_STORE_WIPER: begin
              if (wp_ok) begin
                d.st = wiper_pkg::ST_STORE;
                d.st_addr = {3'h0, sel};
                d.st_data = {6'h0, w_sel};
                d.busy_cnt = 20'(STORE_CYCLES - 1);
              end
            end
            wiper_pkg::CMD_STORE_DATA: begin
              if (wp_ok && addr != wiper_pkg::NV_FACTORY_ADDR) begin
                d.st = wiper_pkg::ST_STORE;
                d.st_addr = addr;
                d.st_data = data;
                d.busy_cnt = 20'(STORE_CYCLES - 1);
              end
            end
            wiper_pkg::CMD_HALVE_ONE, wiper_pkg::CMD_DEC_ONE,
            wiper_pkg::CMD_DOUBLE_ONE, wiper_pkg::CMD_INC_ONE: begin
              if (wp_ok && sel) begin
                d.w2 = step(q.w2, instr);
              end else if (wp_ok) begin
                d.w1 = step(q.w1, instr);
              end
            end
            wiper_pkg::CMD_HALVE_ALL, wiper_pkg::CMD_DEC_ALL,
            wiper_pkg::CMD_DOUBLE_ALL, wiper_pkg::CMD_INC_ALL: begin
              if (wp_ok) begin
                d.w1 = step(q.w1, instr);
                d.w2 = step(q.w2, instr);
              end
            end
            wiper_pkg::CMD_RELOAD_ALL: begin
              d.w1 = q.nv[0][9:0];
              d.w2 = q.nv[1][9:0];
              d.rdy_cnt = wiper_pkg::RDY_PULSE_CYCLES;
            end
            wiper_pkg::CMD_READ_NV: begin
              d.load_stb = 1'b1;
              d.load_word = {instr, addr, q.nv[addr]};
              d.rdy_cnt = wiper_pkg::RDY_PULSE_CYCLES;
            end
            wiper_pkg::CMD_READ_WIPER: begin
              d.load_stb = 1'b1;
              d.load_word = {instr, addr, 6'h0, w_sel};
              d.rdy_cnt = wiper_pkg::RDY_PULSE_CYCLES;
            end
            wiper_pkg::CMD_WRITE: begin
              if (wp_ok && sel) begin
                d.w2 = data[9:0];
              end else if (wp_ok) begin
                d.w1 = data[9:0];
              end
            end
          endcase
        end
      end
      default: begin
        d.st = wiper_pkg::ST_IDLE;
      end
    endcase

    // Preset overrides the wiper result of any command in the same cycle.
    if (!q.pr_s[1]) begin
      d.w1 = wiper_pkg::WIPER_MID;
      d.w2 = wiper_pkg::WIPER_MID;
    end else if (!q.pr_s[2]) begin
      d.w1 = q.nv[0][9:0];
      d.w2 = q.nv[1][9:0];
      d.rdy_cnt = wiper_pkg::RDY_PULSE_CYCLES;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q <= rst_val;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign lk.lock = (q.st != wiper_pkg::ST_IDLE);
  assign lk.load_stb = q.load_stb;
  assign lk.load_word = q.load_word;
  assign rdy_o = 1'b0;
  assign rdy_oe = (q.rdy_cnt != 3'h0);
  assign wiper_one = q.w1;
  assign wiper_two = q.w2;
  assign store_busy = (q.st == wiper_pkg::ST_STORE);
  assign read_power = q.rd_pwr;

endmodule // dual_wiper_serial_command

// ===== hw/wiper_pkg.sv
// Shared constants and types of the dual wiper serial command block.
// Assumes a 40 MHz system clock; all users refer to names as wiper_pkg::name.
package wiper_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int INSTR_LSB = 20;
  localparam int ADDR_LSB = 16;
  localparam int WIPER_BITS = 10;
  localparam int NV_BITS = 16;
  localparam int NV_WORDS = 16;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE_DATA = 4'h3;
  localparam logic [3:0] CMD_HALVE_ONE = 4'h4;
  localparam logic [3:0] CMD_HALVE_ALL = 4'h5;
  localparam logic [3:0] CMD_DEC_ONE = 4'h6;
  localparam logic [3:0] CMD_DEC_ALL = 4'h7;
  localparam logic [3:0] CMD_RELOAD_ALL = 4'h8;
  localparam logic [3:0] CMD_READ_NV = 4'h9;
  localparam logic [3:0] CMD_READ_WIPER = 4'ha;
  localparam logic [3:0] CMD_WRITE = 4'hb;
  localparam logic [3:0] CMD_DOUBLE_ONE = 4'hc;
  localparam logic [3:0] CMD_DOUBLE_ALL = 4'hd;
  localparam logic [3:0] CMD_INC_ONE = 4'he;
  localparam logic [3:0] CMD_INC_ALL = 4'hf;

  // ----------------------------------------------------------------
  // Values and addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] WIPER_MID = 10'h200;
  localparam logic [9:0] WIPER_FULL = 10'h3ff;
  localparam logic [15:0] NV_MID = 16'h0200;
  localparam logic [3:0] NV_FACTORY_ADDR = 4'hf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int STORE_TIME_US = 25_000;
  localparam int STORE_CYCLES = STORE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int STORE_CNT_W = 20;
  localparam logic [2:0] RDY_PULSE_CYCLES = 3'h4;

  typedef enum logic [1:0] {ST_POWERUP, ST_IDLE, ST_STORE} core_state_e;

endpackage

// ===== hw/frame_link_if.sv
// Carrier between the serial front end and the command core.
// Assumes both ends run on the same system clock.
interface frame_link_if;
  logic frame_stb;          // A whole frame of a multiple of 24 bits ended.
  logic [23:0] frame_word;  // Last 24 bits received.
  logic repeat_stb;         // Chip select pulsed with no clock.
  logic lock;               // Core is busy; front end ignores link clocks and chip-select rise.
  logic load_stb;           // Load readback word into the shift register.
  logic [23:0] load_word;   // Readback word.
  modport front (output frame_stb, frame_word, repeat_stb,
                 input lock, load_stb, load_word);
  modport core (input frame_stb, frame_word, repeat_stb,
                output lock, load_stb, load_word);
endinterface

// ===== hw/serial_front.sv
// Serial front end: synchronises the link pins, shifts frames, counts bits.
// Assumes link pins are asynchronous to clk_sys and much slower than it.
module serial_front (
  input wire logic clk_sys,      // System clock.
  input wire logic rstn,         // Synchronous reset, active low.
  input wire logic ce,           // Clock enable.
  input wire logic sclk,         // Link clock pin.
  input wire logic sdi,          // Serial data in pin.
  input wire logic cs_n,         // Chip select pin, active low.
  output logic sdo_o,            // Serial out level, always low.
  output logic sdo_oe,           // Serial out pull-down enable.
  frame_link_if.front lk         // Link to the command core.
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] sdi_s;
    logic [2:0] cs_s;
    logic [23:0] sr;
    logic [4:0] cnt;
    logic any;
    logic rose;
    logic sdo_bit;
    logic frame_stb;
    logic repeat_stb;
  } front_s;

  localparam front_s RST = '{sclk_s: 3'h0, sdi_s: 2'h0, cs_s: 3'h7,
                             sr: 24'h0, cnt: 5'h0, any: 1'b0, rose: 1'b0,
                             sdo_bit: 1'b1, frame_stb: 1'b0,
                             repeat_stb: 1'b0};

  front_s q;
  front_s d;

  // ----------------------------------------------------------------
  // Shift and count
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.frame_stb = 1'b0;
    d.repeat_stb = 1'b0;
    d.sclk_s = {q.sclk_s[1:0], sclk};
    d.sdi_s = {q.sdi_s[0], sdi};
    d.cs_s = {q.cs_s[1:0], cs_n};
    if (q.cs_s[2] && !q.cs_s[1]) begin
      d.cnt = 5'h0;
      d.any = 1'b0;
      d.rose = 1'b0;
      d.sdo_bit = q.sr[23];
    end else if (!q.cs_s[1] && !lk.lock) begin
      if (!q.sclk_s[2] && q.sclk_s[1]) begin
        d.sr = {q.sr[22:0], q.sdi_s[1]};
        d.cnt = (q.cnt == 5'd23) ? 5'h0 : q.cnt + 5'h1;
        d.any = 1'b1;
        d.rose = 1'b1;
      end else if (q.sclk_s[2] && !q.sclk_s[1] && q.rose) begin
        d.sdo_bit = q.sr[23];
      end
    end
    if (!q.cs_s[2] && q.cs_s[1] && !lk.lock) begin
      if (!q.any) begin
        d.repeat_stb = 1'b1;
      end else if (q.cnt == 5'h0) begin
        d.frame_stb = 1'b1;
      end
      if (q.cnt[1:0] != 2'h0) begin
        d.cnt = 5'h0;
      end
    end
    if (lk.load_stb) begin
      d.sr = lk.load_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q <= RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign lk.frame_stb = q.frame_stb;
  assign lk.frame_word = q.sr;
  assign lk.repeat_stb = q.repeat_stb;
  assign sdo_o = 1'b0;
  assign sdo_oe = !q.cs_s[1] && !q.sdo_bit;

endmodule // serial_front

// ===== verif/wiper_properties.sv
// Concurrent checks on the pins of the dual wiper serial command block.
// Assumes one clock domain, clk_sys, with a synchronous active-low reset.
module wiper_properties #(
  parameter int STORE_CYCLES = 20
) (
  input wire logic clk_sys,          // System clock.
  input wire logic rstn,             // Reset, active low.
  input wire logic cs_n,             // Chip select pin.
  input wire logic sdo_o,            // Serial out level.
  input wire logic sdo_oe,           // Serial out pull-down enable.
  input wire logic rdy_o,            // Completion flag level.
  input wire logic rdy_oe,           // Completion flag pull-down enable.
  input wire logic preset_strobe_n,  // Preset strobe pin.
  input wire logic [9:0] wiper_one,  // Wiper one position.
  input wire logic [9:0] wiper_two,  // Wiper two position.
  input wire logic store_busy        // Store in progress.
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy_len_q;
  int cs_low_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_len_q <= 0;
      cs_low_q <= 0;
    end else begin
      busy_len_q <= store_busy ? busy_len_q + 1 : 0;
      cs_low_q <= cs_n ? 0 : (cs_low_q < 63 ? cs_low_q + 1 : 63);
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  rdy_width_a: assert property ($rose(rdy_oe) |-> rdy_oe [*4] ##1 !rdy_oe)
    else $error("completion pulse width wrong");
  od_level_a: assert property (!sdo_o && !rdy_o)
    else $error("open-drain level driven high");
  sdo_release_a: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("serial out pulled low while deselected");
  preset_mid_a: assert property (!preset_strobe_n [*5] |->
    wiper_one == wiper_pkg::WIPER_MID && wiper_two == wiper_pkg::WIPER_MID)
    else $error("wipers not at midscale under preset");
  preset_rdy_a: assert property ($rose(preset_strobe_n) |-> ##[1:6] $rose(rdy_oe))
    else $error("no completion pulse after preset");
  store_len_a: assert property ($fell(store_busy) |->
    busy_len_q >= STORE_CYCLES - 1 && busy_len_q <= STORE_CYCLES + 1)
    else $error("store time wrong");
  store_hold_a: assert property (store_busy && $past(store_busy) && preset_strobe_n
    && $past(preset_strobe_n, 4) |-> $stable(wiper_one) && $stable(wiper_two))
    else $error("wiper changed during store");
  store_rdy_a: assert property ($fell(store_busy) |-> ##[0:2] $rose(rdy_oe))
    else $error("no completion pulse after store");
  frame_hold_a: assert property (cs_low_q >= 8 && preset_strobe_n
    && $past(preset_strobe_n, 4) |-> $stable(wiper_one) && $stable(wiper_two))
    else $error("wiper changed while chip select low");
endmodule // wiper_properties

bind dual_wiper_serial_command wiper_properties #(.STORE_CYCLES(STORE_CYCLES)) i_props (
  .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .rdy_o(rdy_o), .rdy_oe(rdy_oe), .preset_strobe_n(preset_strobe_n),
  .wiper_one(wiper_one), .wiper_two(wiper_two), .store_busy(store_busy));

// ===== verif/link_host.sv
// Host model of the serial link: shifts frames in and captures serial out.
// Assumes it shares clk_sys with the block and serial out has a pull-up.
module link_host (
  input wire logic clk_sys,   // System clock for pacing.
  input wire logic sdo_line,  // Serial out wire level.
  output logic sclk,          // Link clock, still outside frames.
  output logic sdi,           // Serial data to the block.
  output logic cs_n           // Chip select, active low.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Sends the low n bits of d; a zero count gives a bare chip-select pulse.
  task automatic xfer(input logic [47:0] d, input int n, input logic mode3,
                      output logic [47:0] q);
    q = '0;
    sclk <= mode3;
    tick(8);
    cs_n <= 1'b0;
    tick(4);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= d[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      q = {q[46:0], sdo_line};
    end
    if (!mode3) sclk <= 1'b0;
    tick(4);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    tick(8);
  endtask
endmodule // link_host

// ===== verif/tb.sv
// Self-checking bench for the dual wiper serial command block.
// Assumes the host model paces the link at 200 ns per link clock.
`define chk(name, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", name, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STORE_N = 400;
  localparam logic [15:0] FW = 16'h5a5a; // Arbitrary factory word.
  // Steps: command, address, then expected wiper one and two.
  localparam logic [27:0] STEPS [13] = '{
    {4'he, 4'h1, 10'h100, 10'h3ff}, {4'he, 4'h1, 10'h100, 10'h3ff},
    {4'hc, 4'h0, 10'h200, 10'h3ff}, {4'hd, 4'h0, 10'h3ff, 10'h3ff},
    {4'h5, 4'h0, 10'h1ff, 10'h1ff}, {4'h4, 4'h1, 10'h1ff, 10'h0ff},
    {4'h6, 4'h0, 10'h1fe, 10'h0ff}, {4'h7, 4'h0, 10'h1fd, 10'h0fe},
    {4'hf, 4'h0, 10'h1fe, 10'h0ff}, {4'hb, 4'h0, 10'h001, 10'h0ff},
    {4'h4, 4'h0, 10'h000, 10'h0ff}, {4'h4, 4'h0, 10'h000, 10'h0ff},
    {4'h7, 4'h0, 10'h000, 10'h0fe}};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic preset_strobe_n = 1'b1;
  logic write_protect_n = 1'b1;
  logic sclk, sdi, cs_n, sdo_o, sdo_oe, rdy_o, rdy_oe, store_busy, read_power;
  logic [9:0] wiper_one, wiper_two;
  logic [47:0] q;
  logic m3 = 1'b0;
  logic rdy_d = 1'b0;
  int rdy_n = 0;
  int r0 = 0;
  int fails = 0;
  int checks = 0;
  wire logic sdo_line = !sdo_oe;
  dual_wiper_serial_command #(.STORE_CYCLES(STORE_N), .FACTORY_WORD(FW)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .rdy_o(rdy_o), .rdy_oe(rdy_oe),
    .preset_strobe_n(preset_strobe_n), .write_protect_n(write_protect_n),
    .wiper_one(wiper_one), .wiper_two(wiper_two), .store_busy(store_busy),
    .read_power(read_power));
  link_host i_host (.clk_sys(clk_sys), .sdo_line(sdo_line), .sclk(sclk), .sdi(sdi),
    .cs_n(cs_n));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rdy_d <= rdy_oe;
    if (rdy_oe && !rdy_d) rdy_n++;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    i_host.xfer({24'h0, c, a, d}, 24, m3, q);
  endtask
  task automatic wip(input logic [9:0] e1, input logic [9:0] e2);
    `chk("wiper_one", e1, wiper_one)
    `chk("wiper_two", e2, wiper_two)
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    tick(6);
    rstn <= 1'b1;
    tick(8);
    wip(wiper_pkg::WIPER_MID, wiper_pkg::WIPER_MID);
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'hfd00);
    send(wiper_pkg::CMD_WRITE, 4'h3, 16'h03fe);
    wip(10'h100, 10'h3fe);
    send(wiper_pkg::CMD_READ_WIPER, 4'h0, 16'h0000);
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'h0100);
    `chk("readback", {wiper_pkg::CMD_READ_WIPER, 4'h0, 16'h0100}, q[23:0])
    send(wiper_pkg::CMD_NOP, 4'h0, 16'h0000);
    `chk("chain out", {wiper_pkg::CMD_WRITE, 4'h0, 16'h0100}, q[23:0])
    foreach (STEPS[i]) begin
      m3 = i[0];
      send(STEPS[i][27:24], STEPS[i][23:20], {6'h0, STEPS[i][19:10]});
      wip(STEPS[i][19:10], STEPS[i][9:0]);
    end
    m3 = 1'b0;
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'h0155);
    r0 = rdy_n;
    send(wiper_pkg::CMD_STORE_WIPER, 4'h0, 16'h0000);
    `chk("store_busy", 1'b1, store_busy)
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'h00aa);
    tick(STORE_N / 2);
    wip(10'h155, 10'h0fe);
    `chk("store pulses", 1, rdy_n - r0)
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'h0000);
    send(wiper_pkg::CMD_RESTORE, 4'h0, 16'h0000);
    wip(10'h155, 10'h0fe);
    `chk("read_power", 1'b1, read_power)
    send(wiper_pkg::CMD_NOP, 4'h0, 16'h0000);
    `chk("read_power", 1'b0, read_power)
    send(wiper_pkg::CMD_STORE_DATA, 4'h5, 16'hbeef);
    tick(STORE_N);
    send(wiper_pkg::CMD_STORE_DATA, 4'hf, 16'h1234);
    tick(STORE_N);
    send(wiper_pkg::CMD_READ_NV, 4'h5, 16'h0000);
    send(wiper_pkg::CMD_READ_NV, 4'hf, 16'h0000);
    `chk("user word", {wiper_pkg::CMD_READ_NV, 4'h5, 16'hbeef}, q[23:0])
    send(wiper_pkg::CMD_NOP, 4'h0, 16'h0000);
    `chk("factory word", {wiper_pkg::CMD_READ_NV, 4'hf, FW}, q[23:0])
    preset_strobe_n <= 1'b0;
    tick(8);
    wip(wiper_pkg::WIPER_MID, wiper_pkg::WIPER_MID);
    r0 = rdy_n;
    preset_strobe_n <= 1'b1;
    tick(10);
    wip(10'h155, wiper_pkg::WIPER_MID);
    `chk("preset pulses", 1, rdy_n - r0)
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'h0010);
    write_protect_n <= 1'b0;
    tick(4);
    send(wiper_pkg::CMD_WRITE, 4'h0, 16'h0020);
    send(wiper_pkg::CMD_INC_ALL, 4'h0, 16'h0000);
    wip(10'h010, wiper_pkg::WIPER_MID);
    r0 = rdy_n;
    send(wiper_pkg::CMD_RELOAD_ALL, 4'h0, 16'h0000);
    wip(10'h155, wiper_pkg::WIPER_MID);
    `chk("reload pulses", 1, rdy_n - r0)
    send(wiper_pkg::CMD_NOP, 4'h0, 16'h0000);
    write_protect_n <= 1'b1;
    i_host.xfer({24'h0, wiper_pkg::CMD_WRITE, 20'h0003c}, 23, m3, q);
    i_host.xfer({24'h0, wiper_pkg::CMD_WRITE, 20'h0003c}, 25, m3, q);
    wip(10'h155, wiper_pkg::WIPER_MID);
    i_host.xfer({24'he10001, wiper_pkg::CMD_WRITE, 20'h002aa}, 48, m3, q);
    wip(10'h2aa, wiper_pkg::WIPER_MID);
    `chk("passed frame", 24'he10001, q[23:0])
    send(wiper_pkg::CMD_INC_ONE, 4'h0, 16'h0000);
    i_host.xfer(48'h0, 0, m3, q);
    wip(10'h2ac, wiper_pkg::WIPER_MID);
    conclude();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    conclude();
  end
endmodule // tb
